// >>> rtl/drcl_pkg.sv
/*
  Shared constants of the drive relay condition logic: register offsets,
  field positions, reset values, relay modes and frequency scaling.
  Assumes frequencies arrive as counts of limit frequency / 10000.
*/
package drcl_pkg;
  // frequency counts: full scale is the selected limit frequency
  localparam int FREQ_W = 16;
  localparam logic [15:0] FREQ_FULL = 16'd10000;
  localparam int AT_DIV = 120;
  localparam int FB_DIV = 12;
  localparam int REL_DIV = 24;
  localparam int APPLY_DIV = 40;
  localparam logic [15:0] ON_TARGET_DEF = 16'(int'(FREQ_FULL) / AT_DIV);
  localparam logic [15:0] STANDSTILL_DEF = 16'(int'(FREQ_FULL) / AT_DIV);
  localparam logic [15:0] MEAS_RATE_DEF = 16'(int'(FREQ_FULL) / FB_DIV);
  localparam logic [15:0] REL_FREQ_DEF = 16'(int'(FREQ_FULL) / REL_DIV);
  localparam logic [15:0] APPLY_FREQ_DEF = 16'(int'(FREQ_FULL) / APPLY_DIV);
  localparam logic [15:0] INIT_SP_DEF = 16'h0000;
  localparam logic [15:0] MIN_SPD_DEF = 16'h0000;
  localparam logic [15:0] MAX_SPD_DEF = FREQ_FULL;
  // load in whole percent
  localparam logic [7:0] LOAD_MAX = 8'd150;
  localparam logic [7:0] LOAD_TRIP_DEF = 8'd50;
  localparam logic [7:0] REL_LOAD_DEF = 8'd50;
  // ramp output code, full code is +10V
  localparam int DAC_W = 12;
  localparam logic [11:0] DAC_FULL = 12'hfff;
  // register byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_BOOT = 8'h04;
  localparam logic [7:0] A_MODE = 8'h08;
  localparam logic [7:0] A_ON_TARGET = 8'h0c;
  localparam logic [7:0] A_STANDSTILL = 8'h10;
  localparam logic [7:0] A_LOAD_TRIP = 8'h14;
  localparam logic [7:0] A_MEAS_RATE = 8'h18;
  localparam logic [7:0] A_REL_FREQ = 8'h1c;
  localparam logic [7:0] A_REL_LOAD = 8'h20;
  localparam logic [7:0] A_APPLY_FREQ = 8'h24;
  localparam logic [7:0] A_INIT_SP = 8'h28;
  localparam logic [7:0] A_MIN_SPD = 8'h2c;
  localparam logic [7:0] A_MAX_SPD = 8'h30;
  localparam logic [7:0] A_STATUS = 8'h34;
  localparam logic [7:0] A_PANEL = 8'h38;
  // control register fields
  localparam int C_PANEL = 0;
  localparam int C_DIR = 1;
  localparam int C_AUTO = 2;
  localparam int C_RUN = 3;
  localparam int C_LIM_LO = 4;
  localparam int C_SCL_LO = 6;
  localparam int CTRL_W = 8;
  localparam logic [7:0] CTRL_DEF = 8'h00;
  localparam int M2_LO = 4;
  localparam int PANEL_DIR = 16;
  typedef enum logic [2:0] {
    MODE_OFF, MODE_AT_SPEED, MODE_ZERO, MODE_LOAD, MODE_FB, MODE_BRAKE
  } drcl_mode_t;
  typedef enum logic [1:0] {LIM_120, LIM_240, LIM_480} drcl_lim_t;
  typedef enum logic [1:0] {
    SCALE_SPAN_LOW_HIGH, SCALE_ZERO_TO_TOP, SCALE_ZERO_TO_HIGH
  } drcl_scale_t;
endpackage : drcl_pkg

// >>> rtl/drcl_ramp_scale.sv
/*
  Ramp output scaler: maps a frequency between lo and hi onto the full
  output code by a serial restoring divide. Assumes lo <= hi; a zero span
  gives code zero. The code refreshes once per conversion.
*/
`timescale 1ns/100ps
module drcl_ramp_scale
  import drcl_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [FREQ_W-1:0] val_i,
  input wire logic [FREQ_W-1:0] lo_i,
  input wire logic [FREQ_W-1:0] hi_i,
  output logic [DAC_W-1:0] code_o
);
  import drcl_pkg::*;
  localparam int NUM_W = FREQ_W + DAC_W;
  typedef enum logic {IDLE, BUSY} drcl_div_t;
  drcl_div_t state;
  logic [NUM_W-1:0] quo;
  logic [FREQ_W:0] rem;
  logic [FREQ_W-1:0] den;
  logic [4:0] cnt;
  wire [FREQ_W-1:0] xc = (val_i < lo_i) ? lo_i :
                         (val_i > hi_i) ? hi_i : val_i;
  wire [FREQ_W-1:0] span = hi_i - lo_i;
  // widen both factors first, a 16-bit product would wrap
  wire [NUM_W-1:0] num = NUM_W'(xc - lo_i) * NUM_W'(DAC_FULL);
  wire [FREQ_W:0] rem_sh = {rem[FREQ_W-1:0], quo[NUM_W-1]};
  wire fits = rem_sh >= {1'b0, den};

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= IDLE;
      quo <= '0;
      rem <= '0;
      den <= '0;
      cnt <= '0;
      code_o <= '0;
    end else begin
      unique case (state)
        IDLE: begin
          quo <= num;
          rem <= '0;
          den <= span;
          cnt <= 5'(NUM_W - 1);
          state <= BUSY;
        end
        BUSY: begin
          rem <= fits ? rem_sh - {1'b0, den} : rem_sh;
          quo <= {quo[NUM_W-2:0], fits};
          cnt <= cnt - 5'd1;
          if (cnt == 5'd0) begin
            state <= IDLE;
            // the quotient can not exceed full code once xc <= hi
            code_o <= (den == '0) ? '0 : DAC_W'({quo[NUM_W-2:0], fits});
          end
        end
      endcase
    end
  end
endmodule : drcl_ramp_scale

// >>> rtl/drcl_top.sv
/*
  Drive relay condition logic: two reconfigurable relays, ramp output
  scaling, limit frequency choice and operator panel power-up settings.
  Assumes drive-side inputs share clk_sys_i; the terminal run pin is
  asynchronous. Frequencies are counts of limit frequency / 10000.
*/
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/100ps
module drcl_top
  import drcl_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [drcl_pkg::ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [drcl_pkg::FREQ_W-1:0] out_freq_i,
  input wire logic [drcl_pkg::FREQ_W-1:0] meas_speed_i,
  input wire logic [7:0] load_i,
  input wire logic [drcl_pkg::FREQ_W-1:0] term_sp_i,
  input wire logic term_run_i,
  output logic relay_output_one_o,
  output logic relay_output_two_o,
  output logic run_o,
  output logic dir_rev_o,
  output logic panel_sel_o,
  output logic [drcl_pkg::FREQ_W-1:0] speed_demand_o,
  output logic [1:0] top_freq_choice_o,
  output logic [drcl_pkg::DAC_W-1:0] ramp_code_o
);
  import drcl_pkg::*;

  function automatic logic [15:0] clip_freq(input logic [31:0] v);
    clip_freq = (v > 32'(FREQ_FULL)) ? FREQ_FULL : v[15:0];
  endfunction : clip_freq

  function automatic logic [7:0] clip_load(input logic [31:0] v);
    clip_load = (v > 32'(LOAD_MAX)) ? LOAD_MAX : v[7:0];
  endfunction : clip_load

  function automatic logic [15:0] abs_diff(input logic [15:0] a,
                                           input logic [15:0] b);
    abs_diff = (a > b) ? a - b : b - a;
  endfunction : abs_diff

  // registers
  logic [CTRL_W-1:0] ctrl;
  drcl_mode_t mode_one, mode_two;
  logic [15:0] on_target_band, standstill_band, measured_rate_level;
  logic [15:0] brake_release_freq, brake_apply_freq, init_sp;
  logic [15:0] min_spd, max_spd, panel_sp;
  logic [7:0] load_trip_level, rel_load;
  logic dir_live, panel_q, booted;
  logic term_run_m, term_run_s;

  // decode
  wire wr_ctrl = wr_i && addr_i == A_CTRL;
  wire boot = wr_i && addr_i == A_BOOT;
  wire wr_panel = wr_i && addr_i == A_PANEL;
  wire panel = ctrl[C_PANEL];
  wire panel_rise = panel && !panel_q;
  wire load_panel = boot || panel_rise;
  wire [15:0] wfreq = clip_freq(wdata_i);
  wire [7:0] wload = clip_load(wdata_i);
  wire [1:0] wlim = (wdata_i[C_LIM_LO+:2] == 2'h3) ? 2'(LIM_120)
                                                  : wdata_i[C_LIM_LO+:2];
  wire [1:0] wscl = (wdata_i[C_SCL_LO+:2] == 2'h3) ? 2'(SCALE_SPAN_LOW_HIGH)
                                                  : wdata_i[C_SCL_LO+:2];
  wire auto_go = boot && panel && ctrl[C_AUTO];
  wire [CTRL_W-1:0] wctrl = {wscl, wlim, wdata_i[3:0]};

  // condition terms
  wire [15:0] at_dev = abs_diff(out_freq_i, speed_demand_o);
  wire at_speed = at_dev <= on_target_band;
  wire at_zero = out_freq_i <= standstill_band;
  wire load_reached_relay = load_i > load_trip_level;
  wire fb_high = meas_speed_i > measured_rate_level;
  wire brk_rel = out_freq_i > brake_release_freq && load_i > rel_load;
  wire brk_app = out_freq_i < brake_apply_freq;

  function automatic logic relay_next(input drcl_mode_t m,
                                      input logic cur);
    relay_next = 1'b0;
    unique case (m)
      MODE_OFF: relay_next = 1'b0;
      MODE_AT_SPEED: relay_next = at_speed;
      MODE_ZERO: relay_next = at_zero;
      MODE_LOAD: relay_next = load_reached_relay;
      MODE_FB: relay_next = fb_high;
      MODE_BRAKE: relay_next = brk_app ? 1'b0 : (brk_rel ? 1'b1 : cur);
      default: relay_next = 1'b0;
    endcase
  endfunction : relay_next

  wire next_relay_one = relay_next(mode_one, relay_output_one_o);
  wire next_relay_two = relay_next(mode_two, relay_output_two_o);
  wire next_run = panel ? ctrl[C_RUN] : term_run_s;
  wire [15:0] next_demand = clip_freq(32'(panel ? panel_sp : term_sp_i));

  // ramp range choice
  wire [15:0] ramp_lo = (ctrl[C_SCL_LO+:2] == 2'(SCALE_SPAN_LOW_HIGH))
                        ? min_spd : 16'h0000;
  wire [15:0] ramp_hi = (ctrl[C_SCL_LO+:2] == 2'(SCALE_ZERO_TO_TOP))
                        ? FREQ_FULL : max_spd;

  // read mux
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (addr_i)
      A_CTRL: next_rdata = 32'(ctrl);
      A_MODE: next_rdata = 32'({1'b0, mode_two, 1'b0, mode_one});
      A_ON_TARGET: next_rdata = 32'(on_target_band);
      A_STANDSTILL: next_rdata = 32'(standstill_band);
      A_LOAD_TRIP: next_rdata = 32'(load_trip_level);
      A_MEAS_RATE: next_rdata = 32'(measured_rate_level);
      A_REL_FREQ: next_rdata = 32'(brake_release_freq);
      A_REL_LOAD: next_rdata = 32'(rel_load);
      A_APPLY_FREQ: next_rdata = 32'(brake_apply_freq);
      A_INIT_SP: next_rdata = 32'(init_sp);
      A_MIN_SPD: next_rdata = 32'(min_spd);
      A_MAX_SPD: next_rdata = 32'(max_spd);
      A_STATUS: next_rdata = 32'({booted, panel_sel_o, dir_rev_o, run_o,
                                  relay_output_two_o, relay_output_one_o});
      A_PANEL: next_rdata = 32'({dir_live, panel_sp});
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // terminal run pin crosses in through two flops
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      term_run_m <= 1'b0;
      term_run_s <= 1'b0;
    end else begin
      term_run_m <= term_run_i;
      term_run_s <= term_run_m;
    end
  end

  // parameter registers, frequency and load writes clipped to their legal range
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_one <= MODE_OFF;
      mode_two <= MODE_OFF;
      on_target_band <= ON_TARGET_DEF;
      standstill_band <= STANDSTILL_DEF;
      load_trip_level <= LOAD_TRIP_DEF;
      measured_rate_level <= MEAS_RATE_DEF;
      brake_release_freq <= REL_FREQ_DEF;
      rel_load <= REL_LOAD_DEF;
      brake_apply_freq <= APPLY_FREQ_DEF;
      init_sp <= INIT_SP_DEF;
      min_spd <= MIN_SPD_DEF;
      max_spd <= MAX_SPD_DEF;
    end else if (wr_i) begin
      unique case (addr_i)
        A_MODE: begin
          mode_one <= drcl_mode_t'(wdata_i[2:0]);
          mode_two <= drcl_mode_t'(wdata_i[M2_LO+:3]);
        end
        A_ON_TARGET: on_target_band <= wfreq;
        A_STANDSTILL: standstill_band <= wfreq;
        A_LOAD_TRIP: load_trip_level <= wload;
        A_MEAS_RATE: measured_rate_level <= wfreq;
        A_REL_FREQ: brake_release_freq <= wfreq;
        A_REL_LOAD: rel_load <= wload;
        A_APPLY_FREQ: brake_apply_freq <= wfreq;
        A_INIT_SP: init_sp <= wfreq;
        A_MIN_SPD: min_spd <= wfreq;
        A_MAX_SPD: max_spd <= wfreq;
        default: ;
      endcase
    end
  end

  // control, panel state; load events win over a panel write
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl <= CTRL_DEF;
      panel_q <= 1'b0;
      booted <= 1'b0;
      panel_sp <= INIT_SP_DEF;
      dir_live <= 1'b0;
    end else begin
      panel_q <= panel;
      if (wr_ctrl) begin
        ctrl <= wctrl;
      end else if (auto_go) begin
        ctrl[C_RUN] <= 1'b1;
      end
      if (boot) begin
        booted <= 1'b1;
      end
      if (load_panel) begin
        panel_sp <= init_sp;
        dir_live <= ctrl[C_DIR];
      end else if (wr_panel) begin
        panel_sp <= wfreq;
        dir_live <= wdata_i[PANEL_DIR];
      end
    end
  end

  // outputs
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      relay_output_one_o <= 1'b0;
      relay_output_two_o <= 1'b0;
      run_o <= 1'b0;
      dir_rev_o <= 1'b0;
      panel_sel_o <= 1'b0;
      speed_demand_o <= '0;
      top_freq_choice_o <= 2'(LIM_120);
      rdata_o <= 32'h0000_0000;
    end else begin
      relay_output_one_o <= next_relay_one;
      relay_output_two_o <= next_relay_two;
      run_o <= next_run;
      dir_rev_o <= dir_live;
      panel_sel_o <= panel;
      speed_demand_o <= next_demand;
      top_freq_choice_o <= ctrl[C_LIM_LO+:2];
      rdata_o <= rd_i ? next_rdata : 32'h0000_0000;
    end
  end

  drcl_ramp_scale u_ramp (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .val_i(out_freq_i),
    .lo_i(ramp_lo),
    .hi_i(ramp_hi),
    .code_o(ramp_code_o)
  );

  at_speed_a: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    mode_one == MODE_AT_SPEED && at_dev <= on_target_band
    |=> relay_output_one_o)
    else $error("at-speed relay not closed inside band");

  zero_band_a: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    mode_two == MODE_ZERO && out_freq_i > standstill_band
    |=> !relay_output_two_o)
    else $error("zero-speed relay closed outside band");

  load_trip_a: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    mode_one == MODE_LOAD |=> relay_output_one_o ==
      ($past(load_i) > $past(load_trip_level)))
    else $error("load relay disagrees with trip level");

  fb_close_a: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    mode_two == MODE_FB && meas_speed_i > measured_rate_level
    |=> relay_output_two_o)
    else $error("feedback relay not closed above level");

  fb_open_a: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    mode_two == MODE_FB && meas_speed_i <= measured_rate_level
    |=> !relay_output_two_o)
    else $error("feedback relay not open at or below level");

  brake_hold_a: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    mode_one == MODE_BRAKE && !relay_output_one_o &&
    !(out_freq_i > brake_release_freq && load_i > rel_load)
    |=> !relay_output_one_o)
    else $error("brake released without both conditions");

  brake_apply_a: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    mode_one == MODE_BRAKE && out_freq_i < brake_apply_freq
    |=> !relay_output_one_o)
    else $error("brake not applied below apply frequency");

  demand_limit_a: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    speed_demand_o <= FREQ_FULL)
    else $error("speed demand above limit frequency");

  boot_load_a: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    boot |=> ##1 speed_demand_o == $past(init_sp, 2) || !panel_sel_o)
    else $error("panel setpoint not loaded at power-up");

  auto_start_a: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    boot && !panel && !wr_ctrl |=> ##1 run_o == $past(term_run_s))
    else $error("auto start acted under terminal control");

  brake_release_a: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    mode_one == MODE_BRAKE && out_freq_i >= brake_apply_freq &&
    out_freq_i > brake_release_freq && load_i > rel_load
    |=> relay_output_one_o)
    else $error("brake not released with both conditions");

  auto_run_a: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    boot && panel && ctrl[C_AUTO] && !wr_ctrl |=> ##1 run_o)
    else $error("auto start did not run the drive");

  dir_load_a: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    load_panel |=> ##1 dir_rev_o == $past(ctrl[C_DIR], 2))
    else $error("stored direction not loaded");

  term_source_a: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    !panel |=> run_o == $past(term_run_s))
    else $error("run not taken from terminals");
endmodule : drcl_top

// >>> verif/drcl_brake_model.sv
/*
  Hoist brake partner: the relay coil drives the brake through an outside
  phase-loss interlock. Assumes relay one is set to brake mode when used.
*/
`timescale 1ns/100ps
module drcl_brake_model (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic relay_i,
  input wire logic phase_lost_i,
  output logic brake_open_o
);
  // phase loss interlock
  // in series with the coil: a lost phase fools the load estimate
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      brake_open_o <= 1'b0;
    end else begin
      brake_open_o <= relay_i && !phase_lost_i;
    end
  end
endmodule : drcl_brake_model

// >>> verif/drcl_top_tb.sv
/*
  Self-checking bench of the relay condition logic: register bus reads are
  queued and compared by a monitor. Assumes one 200 MHz clock.
*/
`timescale 1ns/100ps
module drcl_top_tb;
  import drcl_pkg::*;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0, rd_i = 1'b0, rd_d = 1'b0;
  logic [15:0] out_freq_i = 16'h0, meas_speed_i = 16'h0, term_sp_i = 16'h0;
  logic [7:0] load_i = 8'h00;
  logic term_run_i = 1'b0, phase_lost = 1'b0;
  wire [31:0] rdata_o;
  wire r1, r2, run, dir, psel, brake_open;
  wire [15:0] dem;
  wire [1:0] lim;
  wire [11:0] ramp;
  int miscompares = 0, checks = 0, seed = 39;
  logic [31:0] exp_q[$], msk_q[$];
  logic [15:0] f;
  logic [7:0] ra[11] = '{8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24,
    8'h28, 8'h2c, 8'h30, 8'h00};
  logic [31:0] rv[11] = '{32'h2710 / 120, 32'h2710 / 120, 32'h32,
    32'h2710 / 12, 32'h2710 / 24, 32'h32, 32'h2710 / 40, 32'h0, 32'h0,
    32'h2710, 32'h0};

  always #2.5 clk_sys_i = ~clk_sys_i;

  drcl_top dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .out_freq_i(out_freq_i), .meas_speed_i(meas_speed_i), .load_i(load_i),
    .term_sp_i(term_sp_i), .term_run_i(term_run_i),
    .relay_output_one_o(r1), .relay_output_two_o(r2), .run_o(run),
    .dir_rev_o(dir), .panel_sel_o(psel), .speed_demand_o(dem),
    .top_freq_choice_o(lim), .ramp_code_o(ramp));

  drcl_brake_model bm (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .relay_i(r1), .phase_lost_i(phase_lost), .brake_open_o(brake_open));

  task check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task test_done;
    if (miscompares == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk_sys_i);
    exp_q.push_back(e);
    msk_q.push_back(m);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
  endtask : rd

  // relays are registered behind a registered demand, so allow settling
  task stp(input logic [15:0] fq, input logic [15:0] m, input logic [7:0] l,
    input logic [31:0] e);
    @(posedge clk_sys_i);
    out_freq_i <= fq;
    meas_speed_i <= m;
    load_i <= l;
    repeat (4) @(posedge clk_sys_i);
    rd(A_STATUS, e, 32'h3);
  endtask : stp

  task rampw(input logic [15:0] fq, input logic [11:0] e);
    @(posedge clk_sys_i);
    out_freq_i <= fq;
    repeat (2) @(posedge clk_sys_i);
    for (int k = 0; k < 100 && ramp !== e; k++) @(posedge clk_sys_i);
    check({20'h0, ramp}, {20'h0, e});
  endtask : rampw

  always @(posedge clk_sys_i) begin
    if (rd_d) begin
      check(rdata_o & msk_q.pop_front(), exp_q.pop_front());
    end
    rd_d <= rd_i;
  end

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    miscompares++;
    test_done();
  end

  initial begin
    repeat (10) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    for (int i = 0; i < 11; i++) rd(ra[i], rv[i], 32'hffffffff);
    wr(8'h3c, 32'h1234);
    rd(8'h3c, 32'h0, 32'hffffffff);
    wr(A_ON_TARGET, 32'h4e20);
    rd(A_ON_TARGET, 32'h2710, 32'hffff);
    wr(A_LOAD_TRIP, 32'hc8);
    rd(A_LOAD_TRIP, 32'h96, 32'hff);
    wr(A_ON_TARGET, 32'h53);
    wr(A_LOAD_TRIP, 32'h32);
    wr(A_MODE, 32'h21);
    term_sp_i <= 16'h1388;
    stp(16'h13db, 16'h0, 8'h0, 32'h1);
    stp(16'h13dc, 16'h0, 8'h0, 32'h0);
    stp(16'h1335, 16'h0, 8'h0, 32'h1);
    stp(16'h1334, 16'h0, 8'h0, 32'h0);
    term_sp_i <= 16'h3c;
    for (int i = 0; i < 16; i++) begin
      f = 16'($unsigned($random(seed)) % 251);
      stp(f, 16'h0, 8'h0, {30'h0, f <= 16'h53,
        (f > 16'h3c ? f - 16'h3c : 16'h3c - f) <= 16'h53});
    end
    wr(A_MODE, 32'h43);
    stp(16'h0, 16'h341, 8'h32, 32'h0);
    stp(16'h0, 16'h342, 8'h33, 32'h3);
    stp(16'h0, 16'h341, 8'h33, 32'h1);
    stp(16'h0, 16'h342, 8'h32, 32'h2);
    wr(A_MODE, 32'h05);
    stp(16'hc8, 16'h0, 8'h3c, 32'h0);
    stp(16'h1a0, 16'h0, 8'h3c, 32'h0);
    stp(16'h1a1, 16'h0, 8'h32, 32'h0);
    stp(16'h1a1, 16'h0, 8'h33, 32'h1);
    check({31'h0, brake_open}, 32'h1);
    stp(16'hfa, 16'h0, 8'h33, 32'h1);
    phase_lost <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    check({31'h0, brake_open}, 32'h0);
    phase_lost <= 1'b0;
    stp(16'hf9, 16'h0, 8'h33, 32'h0);
    wr(A_INIT_SP, 32'h4e20);
    rd(A_INIT_SP, 32'h2710, 32'hffff);
    wr(A_INIT_SP, 32'h4d2);
    wr(A_CTRL, 32'h07);
    rd(A_PANEL, 32'h104d2, 32'h1ffff);
    wr(A_BOOT, 32'h1);
    rd(A_STATUS, 32'h3c, 32'h3c);
    check({16'h0, dem}, 32'h4d2);
    wr(A_PANEL, 32'h1_4e20);
    rd(A_PANEL, 32'h1_2710, 32'h1ffff);
    check({16'h0, dem}, 32'h2710);
    wr(A_CTRL, 32'h04);
    wr(A_BOOT, 32'h1);
    rd(A_STATUS, 32'h0, 32'h14);
    term_run_i <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    rd(A_STATUS, 32'h4, 32'h4);
    term_run_i <= 1'b0;
    for (int i = 1; i < 4; i++) begin
      wr(A_CTRL, 32'(i) << 4);
      repeat (2) @(posedge clk_sys_i);
      check({30'h0, lim}, i == 3 ? 32'h0 : 32'(i));
      rd(A_CTRL, i == 3 ? 32'h0 : 32'(i) << 4, 32'h30);
    end
    wr(A_CTRL, 32'h0);
    wr(A_MIN_SPD, 32'h7d0);
    rampw(16'h7d0, 12'h000);
    rampw(16'h2710, 12'hfff);
    wr(A_CTRL, 32'h40);
    rampw(16'h0, 12'h000);
    rampw(16'h1388, 12'h7ff);
    wr(A_MAX_SPD, 32'h1388);
    wr(A_CTRL, 32'h80);
    rampw(16'h1388, 12'hfff);
    repeat (4) @(posedge clk_sys_i);
    test_done();
  end
endmodule : drcl_top_tb
